// ===== src/cfc_pkg.sv
package cfc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CFC_OFS_CONTROL  = 8'h00;
  localparam logic [7:0] CFC_OFS_STATUS   = 8'h04;
  localparam logic [7:0] CFC_OFS_IN_WORD  = 8'h08;
  localparam logic [7:0] CFC_OFS_OUT_WORD = 8'h0c;
  localparam logic [7:0] CFC_OFS_XFER     = 8'h10;
  localparam logic [7:0] CFC_OFS_MASK     = 8'h14;
  localparam logic [7:0] CFC_OFS_RAW      = 8'h18;
  localparam logic [7:0] CFC_OFS_MASKED   = 8'h1c;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int CFC_CTL_DIR    = 2;
  localparam int CFC_CTL_MODE_L = 3;
  localparam int CFC_CTL_MODE_H = 5;
  localparam int CFC_CTL_SWAP_L = 6;
  localparam int CFC_CTL_SWAP_H = 7;
  localparam int CFC_CTL_KEY_L  = 8;
  localparam int CFC_CTL_KEY_H  = 9;
  localparam int CFC_CTL_FLUSH  = 14;
  localparam int CFC_CTL_ENABLE = 15;

  localparam int CFC_ST_IN_EMPTY    = 0;
  localparam int CFC_ST_IN_NOT_FULL = 1;
  localparam int CFC_ST_OUT_NEMPTY  = 2;
  localparam int CFC_ST_OUT_FULL    = 3;
  localparam int CFC_ST_BUSY        = 4;

  localparam int CFC_IRQ_IN  = 0;
  localparam int CFC_IRQ_OUT = 1;

  localparam logic [31:0] CFC_RESET_CONTROL = 32'h0000_0000;
  localparam logic [1:0]  CFC_RESET_2BIT    = 2'h0;

  // ****************************************************************
  // queues and bursts
  // ****************************************************************
  localparam int CFC_DEPTH          = 8;
  localparam int CFC_IN_SERVICE_LVL = 4;
  localparam int CFC_BURST_AES      = 4;
  localparam int CFC_BURST_DES      = 2;
  localparam int CFC_LAT_BLOCK      = 16;
  localparam int CFC_LAT_KEY        = 24;

  typedef enum logic [2:0] {
    CFC_TDES_ECB = 3'b000,
    CFC_TDES_CBC = 3'b001,
    CFC_DES_ECB  = 3'b010,
    CFC_DES_CBC  = 3'b011,
    CFC_AES_ECB  = 3'b100,
    CFC_AES_CBC  = 3'b101,
    CFC_AES_CTR  = 3'b110,
    CFC_AES_KEY  = 3'b111
  } cfc_mode_t;

  typedef enum logic [1:0] {
    CFC_SWAP_WORD = 2'b00,
    CFC_SWAP_HALF = 2'b01,
    CFC_SWAP_BYTE = 2'b10,
    CFC_SWAP_BIT  = 2'b11
  } cfc_swap_t;

  typedef enum logic [1:0] {
    CFC_KEY_128 = 2'b00,
    CFC_KEY_192 = 2'b01,
    CFC_KEY_256 = 2'b10,
    CFC_KEY_RSV = 2'b11
  } cfc_key_t;

endpackage : cfc_pkg

// ===== src/cfc_queue_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cfc_queue_if #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
);
  logic                   push;
  logic [WIDTH-1:0]       pushData;
  logic                   pop;
  logic [WIDTH-1:0]       popData;
  logic                   flush;
  logic [$clog2(DEPTH):0] level;
  logic                   empty;
  logic                   full;

  modport queue (input push, pushData, pop, flush, output popData, level, empty, full);
  modport user  (output push, pushData, pop, flush, input popData, level, empty, full);
endinterface : cfc_queue_if
`default_nettype wire

// ===== src/cfc_queue.sv
`timescale 1ns/1ns
`default_nettype none
module cfc_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,      // bus clock
  input wire logic reset_n,  // synchronous reset, active low
  cfc_queue_if.queue q       // queue port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;

  // pushes into a full queue are dropped unless a pop comes in the same cycle; pops from an empty one are dropped
  assign doPush    = q.push && (!q.full || doPop);
  assign doPop     = q.pop && !q.empty;
  assign q.level   = count;
  assign q.empty   = (count == '0);
  assign q.full    = (count == (AW+1)'(DEPTH));
  assign q.popData = store[rdPtr];

  always_ff @(posedge clk) begin
    if (!reset_n || q.flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wrPtr] <= q.pushData;
    end
  end
endmodule : cfc_queue
`default_nettype wire

// ===== src/cfc_control.sv
`timescale 1ns/1ns
`default_nettype none
module cfc_control
  import cfc_pkg::*;
#(
  parameter int DEPTH     = cfc_pkg::CFC_DEPTH,
  parameter int LAT_BLOCK = cfc_pkg::CFC_LAT_BLOCK,
  parameter int LAT_KEY   = cfc_pkg::CFC_LAT_KEY
) (
  input  wire logic        clk,          // 100 MHz bus clock
  input  wire logic        reset_n,      // synchronous reset, active low
  input  wire logic [7:0]  addr,         // register byte address
  input  wire logic [31:0] wrData,       // write data
  input  wire logic        wrStrobe,     // write strobe
  input  wire logic        rdStrobe,     // read strobe
  output logic      [31:0] rdData,       // read data, cycle after strobe
  output logic             fillRequest,  // transfer request: fill input queue
  output logic             drainRequest, // transfer request: drain output queue
  output logic      [2:0]  burstWords,   // burst length of current mode
  output logic             serviceIrq,   // service interrupt, active high
  output logic             decrypt,      // direction to the cipher core
  output logic      [2:0]  modeSel,      // algorithm and chaining to the core
  output logic      [1:0]  swapSel,      // swap granularity to the core
  output logic      [1:0]  keySel,       // key length to the core
  output logic             keyPrepare    // core busy while the key schedule mode is selected
);
  import cfc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    CFC_IDLE  = 2'b00,
    CFC_LOAD  = 2'b01,
    CFC_CRUNCH = 2'b10,
    CFC_EMIT  = 2'b11
  } cfc_state_t;

  localparam int LW = $clog2(DEPTH) + 1;
  localparam int CW = 8;

  cfc_queue_if #(.WIDTH(32), .DEPTH(DEPTH)) inQ ();
  cfc_queue_if #(.WIDTH(32), .DEPTH(DEPTH)) outQ ();

  logic            directionSelect;
  cfc_mode_t       algorithmChainingSelect;
  cfc_swap_t       swapGranularitySelect;
  cfc_key_t        keyLengthSelect;
  logic            processorEnable;
  logic            transferInRequestEnable;
  logic            transferOutRequestEnable;
  logic            inServiceMask;
  logic            outServiceMask;
  cfc_state_t      state;
  logic [CW-1:0]   cycles;
  logic [2:0]      wordCount;
  logic [31:0]     block [4];
  logic            busy;
  logic            inServiceRaw;
  logic            outServiceRaw;
  logic            inServiceMasked;
  logic            outServiceMasked;
  logic            wrCtl;
  logic            coreTake;
  logic            coreGive;
  logic [2:0]      blockWords;
  logic            keyRun;

  function automatic logic [2:0] cfc_block_words(input cfc_mode_t m);
    // a block is four words for AES, two for DES and triple DES
    return (m[2]) ? 3'(CFC_BURST_AES) : 3'(CFC_BURST_DES);
  endfunction : cfc_block_words

  function automatic logic [31:0] cfc_swap(input logic [31:0] w, input cfc_swap_t s);
    logic [31:0] r;
    r = w;
    unique case (s)
      CFC_SWAP_WORD: r = w;
      CFC_SWAP_HALF: r = {w[15:0], w[31:16]};
      CFC_SWAP_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      CFC_SWAP_BIT: begin
        for (int i = 0; i < 32; i++) begin
          r[i] = w[31-i];
        end
      end
    endcase
    return r;
  endfunction : cfc_swap

  // ****************************************************************
  // register writes
  // ****************************************************************
  assign wrCtl = wrStrobe && (addr == CFC_OFS_CONTROL);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      directionSelect         <= CFC_RESET_CONTROL[CFC_CTL_DIR];
      algorithmChainingSelect <= CFC_TDES_ECB;
      swapGranularitySelect   <= CFC_SWAP_WORD;
      keyLengthSelect         <= CFC_KEY_128;
      processorEnable         <= CFC_RESET_CONTROL[CFC_CTL_ENABLE];
    end else if (wrCtl) begin
      directionSelect         <= wrData[CFC_CTL_DIR];
      algorithmChainingSelect <= cfc_mode_t'(wrData[CFC_CTL_MODE_H:CFC_CTL_MODE_L]);
      swapGranularitySelect   <= cfc_swap_t'(wrData[CFC_CTL_SWAP_H:CFC_CTL_SWAP_L]);
      keyLengthSelect         <= cfc_key_t'(wrData[CFC_CTL_KEY_H:CFC_CTL_KEY_L]);
      processorEnable         <= wrData[CFC_CTL_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      transferInRequestEnable  <= CFC_RESET_2BIT[0];
      transferOutRequestEnable <= CFC_RESET_2BIT[1];
    end else if (wrStrobe && addr == CFC_OFS_XFER) begin
      transferInRequestEnable  <= wrData[0];
      transferOutRequestEnable <= wrData[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inServiceMask  <= CFC_RESET_2BIT[CFC_IRQ_IN];
      outServiceMask <= CFC_RESET_2BIT[CFC_IRQ_OUT];
    end else if (wrStrobe && addr == CFC_OFS_MASK) begin
      inServiceMask  <= wrData[CFC_IRQ_IN];
      outServiceMask <= wrData[CFC_IRQ_OUT];
    end
  end

  // ****************************************************************
  // queues
  // ****************************************************************
  // flush is judged against the enable held before this write
  assign inQ.flush  = wrCtl && wrData[CFC_CTL_FLUSH] && !processorEnable;
  assign outQ.flush = inQ.flush;

  assign inQ.push     = wrStrobe && (addr == CFC_OFS_IN_WORD);
  assign inQ.pushData = wrData;
  assign inQ.pop      = coreTake;

  assign outQ.push     = coreGive;
  assign outQ.pushData = cfc_swap(block[wordCount[1:0]], swapGranularitySelect);
  assign outQ.pop      = rdStrobe && (addr == CFC_OFS_OUT_WORD);

  cfc_queue #(.WIDTH(32), .DEPTH(DEPTH)) inQueue (
    .clk     (clk),
    .reset_n (reset_n),
    .q       (inQ)
  );

  cfc_queue #(.WIDTH(32), .DEPTH(DEPTH)) outQueue (
    .clk     (clk),
    .reset_n (reset_n),
    .q       (outQ)
  );

  // ****************************************************************
  // core sequencing
  // ****************************************************************
  // the rounds live elsewhere; this sequencer models their latency and
  // moves a block from the input queue to the output queue
  assign blockWords = cfc_block_words(algorithmChainingSelect);
  assign coreTake   = (state == CFC_LOAD) && !inQ.empty && processorEnable;
  assign coreGive   = (state == CFC_EMIT) && !outQ.full && processorEnable;

  always_ff @(posedge clk) begin
    if (!reset_n || inQ.flush) begin
      state     <= CFC_IDLE;
      cycles    <= '0;
      wordCount <= '0;
    end else begin
      unique case (state)
        CFC_IDLE: begin
          wordCount <= '0;
          if (processorEnable && algorithmChainingSelect == CFC_AES_KEY) begin
            state  <= CFC_CRUNCH;
            cycles <= CW'(LAT_KEY);
          end else if (processorEnable
                       && inQ.level >= LW'(blockWords)) begin
            state <= CFC_LOAD;
          end
        end
        CFC_LOAD: begin
          if (!processorEnable) begin
            state <= CFC_IDLE;
          end else if (coreTake) begin
            if (wordCount == blockWords - 3'd1) begin
              state     <= CFC_CRUNCH;
              cycles    <= CW'(LAT_BLOCK);
              wordCount <= '0;
            end else begin
              wordCount <= wordCount + 3'd1;
            end
          end
        end
        CFC_CRUNCH: begin
          if (cycles != '0) begin
            cycles <= cycles - 1'b1;
          end else if (keyRun) begin
            // a finished key run parks here so that it does not start again;
            // a data mode or a cleared enable releases it without emitting
            if (!processorEnable || algorithmChainingSelect != CFC_AES_KEY) begin
              state <= CFC_IDLE;
            end
          end else begin
            state <= CFC_EMIT;
          end
        end
        CFC_EMIT: begin
          if (!processorEnable) begin
            state <= CFC_IDLE;
          end else if (coreGive) begin
            if (wordCount == blockWords - 3'd1) begin
              state     <= CFC_IDLE;
              wordCount <= '0;
            end else begin
              wordCount <= wordCount + 3'd1;
            end
          end
        end
      endcase
    end
  end

  // a key run is recorded on leaving idle, so that a mode write during a
  // run cannot turn a key schedule into a data block or the reverse
  always_ff @(posedge clk) begin
    if (!reset_n || inQ.flush) begin
      keyRun <= 1'b0;
    end else if (state == CFC_IDLE) begin
      keyRun <= processorEnable && (algorithmChainingSelect == CFC_AES_KEY);
    end
  end

  // direction flips data bits as a stand-in for the real transform
  always_ff @(posedge clk) begin
    if (coreTake) begin
      block[wordCount[1:0]] <= cfc_swap(inQ.popData, swapGranularitySelect)
                               ^ {32{directionSelect}};
    end
  end

  // a parked key run reads as idle
  assign busy = (state == CFC_CRUNCH) && (cycles != '0);

  // ****************************************************************
  // service interrupt and transfer requests
  // ****************************************************************
  assign inServiceRaw     = inQ.level < LW'(CFC_IN_SERVICE_LVL);
  assign outServiceRaw    = !outQ.empty;
  assign inServiceMasked  = inServiceRaw && inServiceMask && processorEnable;
  assign outServiceMasked = outServiceRaw && outServiceMask;
  assign serviceIrq       = inServiceMasked || outServiceMasked;

  // a request stands only while a whole burst fits or is available
  assign burstWords   = blockWords;
  assign fillRequest  = transferInRequestEnable && processorEnable
                        && (LW'(DEPTH) - inQ.level >= LW'(blockWords));
  assign drainRequest = transferOutRequestEnable
                        && (outQ.level >= LW'(blockWords));

  assign decrypt    = directionSelect;
  assign modeSel    = algorithmChainingSelect;
  assign swapSel    = swapGranularitySelect;
  assign keySel     = keyLengthSelect;
  assign keyPrepare = busy && (algorithmChainingSelect == CFC_AES_KEY);

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (rdStrobe) begin
      // reserved bits and unmapped offsets read as zero
      rdData <= '0;
      unique case (addr)
        CFC_OFS_CONTROL: begin
          rdData[CFC_CTL_DIR]                   <= directionSelect;
          rdData[CFC_CTL_MODE_H:CFC_CTL_MODE_L] <= algorithmChainingSelect;
          rdData[CFC_CTL_SWAP_H:CFC_CTL_SWAP_L] <= swapGranularitySelect;
          rdData[CFC_CTL_KEY_H:CFC_CTL_KEY_L]   <= keyLengthSelect;
          rdData[CFC_CTL_ENABLE]                <= processorEnable;
        end
        CFC_OFS_STATUS: begin
          rdData[CFC_ST_IN_EMPTY]    <= inQ.empty;
          rdData[CFC_ST_IN_NOT_FULL] <= !inQ.full;
          rdData[CFC_ST_OUT_NEMPTY]  <= !outQ.empty;
          rdData[CFC_ST_OUT_FULL]    <= outQ.full;
          rdData[CFC_ST_BUSY]        <= busy;
        end
        // while enabled the head is still shown; software must not rely on it
        CFC_OFS_IN_WORD:  rdData <= inQ.popData;
        CFC_OFS_OUT_WORD: rdData <= outQ.empty ? '0 : outQ.popData;
        CFC_OFS_XFER: begin
          rdData[0] <= transferInRequestEnable;
          rdData[1] <= transferOutRequestEnable;
        end
        CFC_OFS_MASK: begin
          rdData[CFC_IRQ_IN]  <= inServiceMask;
          rdData[CFC_IRQ_OUT] <= outServiceMask;
        end
        CFC_OFS_RAW: begin
          rdData[CFC_IRQ_IN]  <= inServiceRaw;
          rdData[CFC_IRQ_OUT] <= outServiceRaw;
        end
        CFC_OFS_MASKED: begin
          rdData[CFC_IRQ_IN]  <= inServiceMasked;
          rdData[CFC_IRQ_OUT] <= outServiceMasked;
        end
        default: rdData <= '0;
      endcase
    end
  end
endmodule : cfc_control
`default_nettype wire

// ===== bench/cfc_control_props.sv
`timescale 1ns/1ns
`default_nettype none
module cfc_control_props
  import cfc_pkg::*;
(
  input wire logic        clk,          // bus clock
  input wire logic        reset_n,      // synchronous reset, active low
  input wire logic [7:0]  addr,         // register byte address
  input wire logic [31:0] wrData,       // write data
  input wire logic        wrStrobe,     // write strobe
  input wire logic        rdStrobe,     // read strobe
  input wire logic [31:0] rdData,       // read data
  input wire logic        fillRequest,  // fill request
  input wire logic        drainRequest, // drain request
  input wire logic [2:0]  burstWords,   // burst length
  input wire logic        serviceIrq,   // service interrupt
  input wire logic        decrypt,      // direction
  input wire logic [2:0]  modeSel,      // algorithm and chaining
  input wire logic [1:0]  swapSel,      // swap granularity
  input wire logic [1:0]  keySel,       // key length
  input wire logic        keyPrepare    // busy in key schedule mode
);
  import cfc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ctlWr = wrStrobe && (addr == CFC_OFS_CONTROL);

  AST_DIR: assert property (ctlWr |=> decrypt == $past(wrData[CFC_CTL_DIR]))
    else $error("direction differs from control write");
  AST_MODE: assert property (ctlWr |=> modeSel == $past(wrData[5:3]))
    else $error("mode differs from control write");
  AST_HOLD: assert property (!ctlWr |=> $stable({decrypt, modeSel, swapSel, keySel}))
    else $error("control fields changed without a control write");
  AST_SWAP: assert property (ctlWr |=> swapSel == $past(wrData[7:6]))
    else $error("swap select differs from control write");
  AST_KEY: assert property (ctlWr |=> keySel == $past(wrData[9:8]))
    else $error("key length differs from control write");
  AST_KEYPREP: assert property (keyPrepare |-> modeSel == 3'h7)
    else $error("key schedule runs outside mode seven");
  AST_BURST: assert property (burstWords == (modeSel[2] ? 3'h4 : 3'h2))
    else $error("burst length does not match algorithm");
  AST_MASKED: assert property (rdStrobe && addr == CFC_OFS_MASKED |=>
      rdData[31:2] == 30'h0 && (|rdData[1:0]) == $past(serviceIrq))
    else $error("interrupt is not the or of masked bits");
  AST_BUSY: assert property (rdStrobe && addr == CFC_OFS_STATUS && keyPrepare |=> rdData[4])
    else $error("busy bit low during key schedule");
endmodule : cfc_control_props

bind cfc_control cfc_control_props u_props (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData), .fillRequest(fillRequest),
  .drainRequest(drainRequest), .burstWords(burstWords), .serviceIrq(serviceIrq),
  .decrypt(decrypt), .modeSel(modeSel), .swapSel(swapSel), .keySel(keySel),
  .keyPrepare(keyPrepare));
`default_nettype wire

// ===== bench/cfc_xfer_partner.sv
`timescale 1ns/1ns
`default_nettype none
// transfer controller seen from the block: remembers which requests it got
module cfc_xfer_partner (
  input  wire logic       clk,          // bus clock
  input  wire logic       reset_n,      // synchronous reset, active low
  input  wire logic       fillRequest,  // fill request from block
  input  wire logic       drainRequest, // drain request from block
  input  wire logic [2:0] burstWords,   // burst length from block
  output var  logic       fillSeen,     // a fill request was raised
  output var  logic       drainSeen     // a four-word drain request was raised
);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fillSeen  <= 1'b0;
      drainSeen <= 1'b0;
    end else begin
      if (fillRequest) fillSeen <= 1'b1;
      if (drainRequest && burstWords == 3'h4) drainSeen <= 1'b1;
    end
  end
endmodule : cfc_xfer_partner
`default_nettype wire

// ===== bench/cfc_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cfc_control_tb;
  import cfc_pkg::*;
  logic        clk, reset_n, wrStrobe, rdStrobe, fillRequest, drainRequest, serviceIrq;
  logic        decrypt, keyPrepare, fillSeen, drainSeen, busySeen;
  logic [7:0]  addr;
  logic [31:0] wrData, rdData, rv;
  logic [2:0]  modeSel, burstWords;
  logic [1:0]  swapSel, keySel;
  logic [31:0] ctl;
  int          miscompares, compares;

  cfc_control uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .fillRequest(fillRequest),
    .drainRequest(drainRequest), .burstWords(burstWords), .serviceIrq(serviceIrq),
    .decrypt(decrypt), .modeSel(modeSel), .swapSel(swapSel), .keySel(keySel),
    .keyPrepare(keyPrepare));
  cfc_xfer_partner u_partner (.clk(clk), .reset_n(reset_n), .fillRequest(fillRequest),
    .drainRequest(drainRequest), .burstWords(burstWords), .fillSeen(fillSeen),
    .drainSeen(drainSeen));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  // read data appears in the cycle after the strobe and holds until the next read, so sample it there
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    rv = rdData;
  endtask : rd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rdc

  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {reset_n, wrStrobe, rdStrobe, addr, wrData} = '0;
    miscompares = 0;
    compares = 0;
    busySeen = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdc(CFC_OFS_STATUS, 32'h3);
    rdc(CFC_OFS_RAW, 32'h1);
    rdc(CFC_OFS_MASKED, 32'h0);
    rdc(CFC_OFS_XFER, 32'h0);
    for (int i = 0; i < 8; i++) begin
      ctl = {22'h0, 2'(i), 2'(i), 3'(i), 1'(i), 2'h0};
      wr(CFC_OFS_CONTROL, ctl);
      rdc(CFC_OFS_CONTROL, ctl);
    end
    wr(CFC_OFS_MASK, 32'h3);
    rdc(CFC_OFS_MASK, 32'h3);
    for (int i = 0; i < 3; i++) wr(CFC_OFS_IN_WORD, 32'h5a5a_0000 + 32'(i));
    rdc(CFC_OFS_STATUS, 32'h2);
    rdc(CFC_OFS_RAW, 32'h1);
    rdc(CFC_OFS_MASKED, 32'h0);
    chk({31'h0, serviceIrq}, 32'h0);
    for (int i = 3; i < 9; i++) wr(CFC_OFS_IN_WORD, 32'h5a5a_0000 + 32'(i));
    rdc(CFC_OFS_STATUS, 32'h0);
    rdc(CFC_OFS_RAW, 32'h0);
    rdc(CFC_OFS_IN_WORD, 32'h5a5a_0000);
    wr(CFC_OFS_CONTROL, 32'h0000_4000);
    rdc(CFC_OFS_STATUS, 32'h3);
    wr(CFC_OFS_CONTROL, 32'h0000_8020);
    wr(CFC_OFS_XFER, 32'h1);
    // the partner latches on the edge, so look just after it
    @(posedge clk);
    #1;
    chk({31'h0, fillSeen}, 32'h1);
    for (int i = 0; i < 2; i++) wr(CFC_OFS_IN_WORD, 32'h5a5a_0000 + 32'(i));
    wr(CFC_OFS_CONTROL, 32'h0000_c020);
    rdc(CFC_OFS_STATUS, 32'h2);
    rdc(CFC_OFS_MASKED, 32'h1);
    chk({31'h0, serviceIrq}, 32'h1);
    wr(CFC_OFS_XFER, 32'h2);
    for (int i = 2; i < 8; i++) wr(CFC_OFS_IN_WORD, 32'h5a5a_0000 + 32'(i));
    rv = 32'h0;
    for (int k = 0; k < 100 && rv[3] !== 1'b1; k++) begin
      rd(CFC_OFS_STATUS);
      if (rv[4] === 1'b1) busySeen = 1'b1;
    end
    chk({31'h0, busySeen}, 32'h1);
    rdc(CFC_OFS_STATUS, 32'hf);
    chk({31'h0, drainSeen}, 32'h1);
    rdc(CFC_OFS_RAW, 32'h3);
    rdc(CFC_OFS_MASKED, 32'h3);
    for (int i = 0; i < 8; i++) rdc(CFC_OFS_OUT_WORD, 32'h5a5a_0000 + 32'(i));
    // written into an empty output queue, so a push would show in status
    wr(CFC_OFS_OUT_WORD, 32'hdead_beef);
    rdc(CFC_OFS_STATUS, 32'h3);
    rdc(CFC_OFS_RAW, 32'h1);
    wr(CFC_OFS_MASK, 32'h0);
    rdc(CFC_OFS_MASKED, 32'h0);
    chk({31'h0, serviceIrq}, 32'h0);
    wr(CFC_OFS_CONTROL, 32'h0000_0020);
    for (int i = 0; i < 4; i++) wr(CFC_OFS_IN_WORD, 32'h1234_0000 + 32'(i));
    repeat (20) @(posedge clk);
    rdc(CFC_OFS_STATUS, 32'h2);
    wr(CFC_OFS_CONTROL, 32'h0000_4038);
    rdc(CFC_OFS_STATUS, 32'h3);
    wr(CFC_OFS_CONTROL, 32'h0000_8038);
    rdc(CFC_OFS_STATUS, 32'h13);
    chk({31'h0, keyPrepare}, 32'h1);
    // once the key run is over, a data mode must not emit a stale block
    repeat (30) @(posedge clk);
    wr(CFC_OFS_CONTROL, 32'h0000_8020);
    rdc(CFC_OFS_STATUS, 32'h3);
    rdc(8'h20, 32'h0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : cfc_control_tb
`default_nettype wire
